//--- common/numeric_oscillator_regs.svh
`ifndef NUMERIC_OSCILLATOR_REGS_SVH
`define NUMERIC_OSCILLATOR_REGS_SVH

// byte offsets on the register bus
`define OFS_OSCILLATOR_CONTROL       8'h00
`define OFS_OSCILLATOR_CLOCK_CONTROL 8'h04
`define OFS_ACCUMULATOR_LOW          8'h08
`define OFS_ACCUMULATOR_HIGH         8'h0C
`define OFS_ACCUMULATOR_UPPER        8'h10
`define OFS_INCREMENT_LOW            8'h14
`define OFS_INCREMENT_HIGH           8'h18
`define OFS_IRQ_STATUS               8'h1C
`define OFS_IRQ_CLEAR                8'h20
`define OFS_IRQ_ENABLE               8'h24

// oscillator_control fields
`define POS_MODULE_ON         7
`define POS_PIN_DRIVE_ENABLE  6
`define POS_OUTPUT_LEVEL      5
`define POS_OUTPUT_POLARITY   4
`define POS_PULSE_MODE_SELECT 0

// oscillator_clock_control fields
`define POS_PULSE_WIDTH_LSB   5
`define POS_CLOCK_SOURCE_LSB  0

// clock_source_code values
`define CLK_SRC_FAST_OSC      2'h0
`define CLK_SRC_SYSTEM        2'h1
`define CLK_SRC_LOGIC_CELL    2'h2
`define CLK_SRC_EXT_PIN       2'h3

// interrupt status bit of the overflow event
`define POS_OVERFLOW_FLAG     0

// reset values
`define RST_BYTE_ZERO         8'h00
`define RST_INCREMENT_LOW     8'h01
`define RST_ACCUMULATOR       20'h00000
`define RST_PHASE_STEP        16'h0001

`endif

//--- common/numeric_oscillator_pkg.sv
package numeric_oscillator_pkg;

    typedef struct packed {
        logic module_on;
        logic pin_drive_enable;
        logic output_polarity;
        logic pulse_mode_select;
    } control_t;

    typedef struct packed {
        logic [2:0] pulse_width_code;
        logic [1:0] clock_source_code;
    } clock_control_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] addr;
    } bus_request_t;

    typedef enum logic {
        pulse_idle,
        pulse_active
    } pulse_state_t;

endpackage

//--- hw/numeric_oscillator.sv
// Functional notes
// - oscillator accumulates only while module_on is set; clearing it stops everything
// - pin is driven only while pin_drive_enable is set
// - output_level control bit reads the present output level; writes ignored
// - output_polarity one gives active high, zero active low, applied last
// - pulse_mode_select one selects pulse mode, zero selects fixed duty mode
// - pulse_width_code k gives 2^k input clock periods of active output
// - pulse width code has no effect in fixed duty mode
// - clock_source_code picks fast oscillator, system clock, logic cell or pin
// - 20-bit accumulator in three byte registers; upper bits 7-4 read zero
// - 16-bit increment readable and writable as low and high bytes
// - increment low byte resets to one, at every reset
// - control (output_level bit reads one), clock control, accumulator and increment high reset to zero
// - unimplemented control and clock control bits read zero, writes ignored
// - each selected input clock rising edge adds the increment to the accumulator
// - fixed duty mode toggles the output on every overflow
// - pulse mode drives output active after overflow for the selected width
// - every overflow sets the overflow flag; software clears it
//
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "numeric_oscillator_regs.svh"

module numeric_oscillator #(
    parameter int ACC_WIDTH  = 20,
    parameter int STEP_WIDTH = 16
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        internal_fast_osc,
    input  wire logic        logic_cell_output,
    input  wire logic        external_clock_pin,
    output logic             osc_out,
    output logic             pin_out,
    output logic             pin_oe_n,
    output logic             irq
);

    // ------------------------------------------------------------
    // bus address phase
    // ------------------------------------------------------------
    numeric_oscillator_pkg::bus_request_t req;
    numeric_oscillator_pkg::bus_request_t next_req;

    // only whole-word transfers are expected, so hsize is not decoded
    always_comb begin
        next_req       = '0;
        next_req.valid = hsel & hready & htrans[1];
        next_req.write = hwrite;
        next_req.addr  = haddr[7:0];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req <= '0;
        end else begin
            req <= next_req;
        end
    end

    logic       wr;
    logic [7:0] wbyte;
    assign wr    = req.valid & req.write;
    assign wbyte = hwdata[7:0];

    // ------------------------------------------------------------
    // input clock sources
    // ------------------------------------------------------------
    // three stages: the first only feeds the second, the last two form
    // the edge detector. sources faster than half of hclk are undersampled.
    logic [2:0] src_meta;
    logic [2:0] src_sync;
    logic [2:0] src_prev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_meta <= 3'h0;
            src_sync <= 3'h0;
            src_prev <= 3'h0;
        end else begin
            src_meta <= {external_clock_pin, logic_cell_output, internal_fast_osc};
            src_sync <= src_meta;
            src_prev <= src_sync;
        end
    end

    logic [2:0] src_rise;
    assign src_rise = src_sync & ~src_prev;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    numeric_oscillator_pkg::control_t       ctrl;
    numeric_oscillator_pkg::control_t       next_ctrl;
    numeric_oscillator_pkg::clock_control_t clk_ctrl;
    numeric_oscillator_pkg::clock_control_t next_clk_ctrl;
    logic [7:0]                             step_low;
    logic [7:0]                             next_step_low;
    logic [7:0]                             step_high;
    logic [7:0]                             next_step_high;
    logic [STEP_WIDTH-1:0]                  step_live;
    logic [STEP_WIDTH-1:0]                  next_step_live;

    always_comb begin
        next_ctrl      = ctrl;
        next_clk_ctrl  = clk_ctrl;
        next_step_low  = step_low;
        next_step_high = step_high;
        if (wr && req.addr == `OFS_OSCILLATOR_CONTROL) begin
            next_ctrl.module_on         = wbyte[`POS_MODULE_ON];
            next_ctrl.pin_drive_enable  = wbyte[`POS_PIN_DRIVE_ENABLE];
            next_ctrl.output_polarity   = wbyte[`POS_OUTPUT_POLARITY];
            next_ctrl.pulse_mode_select = wbyte[`POS_PULSE_MODE_SELECT];
        end
        if (wr && req.addr == `OFS_OSCILLATOR_CLOCK_CONTROL) begin
            next_clk_ctrl.pulse_width_code  = wbyte[`POS_PULSE_WIDTH_LSB +: 3];
            next_clk_ctrl.clock_source_code = wbyte[`POS_CLOCK_SOURCE_LSB +: 2];
        end
        if (wr && req.addr == `OFS_INCREMENT_LOW) begin
            next_step_low = wbyte;
        end
        if (wr && req.addr == `OFS_INCREMENT_HIGH) begin
            next_step_high = wbyte;
        end
        // working copy follows at once while stopped; while running it
        // takes both bytes when the low byte is written, so high goes first
        next_step_live = step_live;
        if (!ctrl.module_on || (wr && req.addr == `OFS_INCREMENT_LOW)) begin
            next_step_live = STEP_WIDTH'({next_step_high, next_step_low});
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl      <= '0;
            clk_ctrl  <= '0;
            step_low  <= `RST_INCREMENT_LOW;
            step_high <= `RST_BYTE_ZERO;
            step_live <= STEP_WIDTH'(`RST_PHASE_STEP);
        end else begin
            ctrl      <= next_ctrl;
            clk_ctrl  <= next_clk_ctrl;
            step_low  <= next_step_low;
            step_high <= next_step_high;
            step_live <= next_step_live;
        end
    end

    // ------------------------------------------------------------
    // accumulator and waveform
    // ------------------------------------------------------------
    logic                                 tick;
    logic [ACC_WIDTH-1:0]                 phase_accumulator;
    logic [ACC_WIDTH-1:0]                 next_phase_accumulator;
    logic [ACC_WIDTH:0]                   sum;
    logic                                 overflow;
    logic                                 raw;
    logic                                 next_raw;
    logic [6:0]                           pulse_count;
    logic [6:0]                           next_pulse_count;
    numeric_oscillator_pkg::pulse_state_t pulse_state;
    numeric_oscillator_pkg::pulse_state_t next_pulse_state;

    always_comb begin
        unique case (clk_ctrl.clock_source_code)
            `CLK_SRC_FAST_OSC:   tick = src_rise[0];
            `CLK_SRC_SYSTEM:     tick = 1'b1;
            `CLK_SRC_LOGIC_CELL: tick = src_rise[1];
            `CLK_SRC_EXT_PIN:    tick = src_rise[2];
        endcase
    end

    assign sum      = {1'b0, phase_accumulator} + (ACC_WIDTH + 1)'(step_live);
    assign overflow = ctrl.module_on & tick & sum[ACC_WIDTH];

    always_comb begin
        next_phase_accumulator = phase_accumulator;
        next_raw               = raw;
        next_pulse_count       = pulse_count;
        next_pulse_state       = pulse_state;
        if (!ctrl.module_on) begin
            // stopped: the waveform rests at its inactive level
            next_raw         = 1'b0;
            next_pulse_count = 7'h00;
            next_pulse_state = numeric_oscillator_pkg::pulse_idle;
        end else if (tick) begin
            next_phase_accumulator = sum[ACC_WIDTH-1:0];
            if (!ctrl.pulse_mode_select) begin
                // width code ignored here
                next_pulse_state = numeric_oscillator_pkg::pulse_idle;
                if (overflow) begin
                    next_raw = ~raw;
                end
            end else begin
                unique case (pulse_state)
                    numeric_oscillator_pkg::pulse_idle: begin
                        next_raw = 1'b0;
                    end
                    numeric_oscillator_pkg::pulse_active: begin
                        if (pulse_count == 7'h00) begin
                            next_raw         = 1'b0;
                            next_pulse_state = numeric_oscillator_pkg::pulse_idle;
                        end else begin
                            next_pulse_count = pulse_count - 7'h01;
                        end
                    end
                endcase
                if (overflow) begin
                    // a new overflow restarts the pulse; overlap is undefined
                    next_raw         = 1'b1;
                    next_pulse_state = numeric_oscillator_pkg::pulse_active;
                    next_pulse_count = 7'((8'h01 << clk_ctrl.pulse_width_code) - 8'h01);
                end
            end
        end
        // software byte writes land after the addition of the same cycle
        if (wr && req.addr == `OFS_ACCUMULATOR_LOW) begin
            next_phase_accumulator[7:0] = wbyte;
        end
        if (wr && req.addr == `OFS_ACCUMULATOR_HIGH) begin
            next_phase_accumulator[15:8] = wbyte;
        end
        if (wr && req.addr == `OFS_ACCUMULATOR_UPPER) begin
            next_phase_accumulator[19:16] = wbyte[3:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_accumulator <= ACC_WIDTH'(`RST_ACCUMULATOR);
            raw               <= 1'b0;
            pulse_count       <= 7'h00;
            pulse_state       <= numeric_oscillator_pkg::pulse_idle;
        end else begin
            phase_accumulator <= next_phase_accumulator;
            raw               <= next_raw;
            pulse_count       <= next_pulse_count;
            pulse_state       <= next_pulse_state;
        end
    end

    // ------------------------------------------------------------
    // interrupt status, clear and enable
    // ------------------------------------------------------------
    logic [7:0] irq_status;
    logic [7:0] next_irq_status;
    logic [7:0] irq_enable;
    logic [7:0] next_irq_enable;

    always_comb begin
        next_irq_status = irq_status;
        next_irq_enable = irq_enable;
        if (wr && req.addr == `OFS_IRQ_CLEAR) begin
            next_irq_status = irq_status & ~wbyte;
        end
        // a set in the same cycle as a clear is kept
        if (overflow) begin
            next_irq_status[`POS_OVERFLOW_FLAG] = 1'b1;
        end
        if (wr && req.addr == `OFS_IRQ_ENABLE) begin
            next_irq_enable = wbyte & 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= `RST_BYTE_ZERO;
            irq_enable <= `RST_BYTE_ZERO;
        end else begin
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
        end
    end

    // ------------------------------------------------------------
    // read mux and registered outputs
    // ------------------------------------------------------------
    logic        next_final;
    logic [7:0]  rbyte;
    logic [31:0] next_hrdata;

    // polarity is the last stage before the pins
    assign next_final = ~(next_raw ^ next_ctrl.output_polarity);

    // read data is built from next values, so a read straight after a
    // write returns the freshly written value
    always_comb begin
        rbyte = 8'h00;
        unique case (haddr[7:0])
            `OFS_OSCILLATOR_CONTROL: begin
                rbyte[`POS_MODULE_ON]         = next_ctrl.module_on;
                rbyte[`POS_PIN_DRIVE_ENABLE]  = next_ctrl.pin_drive_enable;
                rbyte[`POS_OUTPUT_LEVEL]      = next_final;
                rbyte[`POS_OUTPUT_POLARITY]   = next_ctrl.output_polarity;
                rbyte[`POS_PULSE_MODE_SELECT] = next_ctrl.pulse_mode_select;
            end
            `OFS_OSCILLATOR_CLOCK_CONTROL: begin
                rbyte[`POS_PULSE_WIDTH_LSB +: 3]  = next_clk_ctrl.pulse_width_code;
                rbyte[`POS_CLOCK_SOURCE_LSB +: 2] = next_clk_ctrl.clock_source_code;
            end
            `OFS_ACCUMULATOR_LOW:   rbyte = next_phase_accumulator[7:0];
            `OFS_ACCUMULATOR_HIGH:  rbyte = next_phase_accumulator[15:8];
            `OFS_ACCUMULATOR_UPPER: rbyte = {4'h0, next_phase_accumulator[19:16]};
            `OFS_INCREMENT_LOW:     rbyte = next_step_low;
            `OFS_INCREMENT_HIGH:    rbyte = next_step_high;
            `OFS_IRQ_STATUS:        rbyte = next_irq_status;
            `OFS_IRQ_ENABLE:        rbyte = next_irq_enable;
            default:                rbyte = 8'h00;
        endcase
        next_hrdata = hrdata;
        if (next_req.valid && !next_req.write) begin
            next_hrdata = {24'h000000, rbyte};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            osc_out   <= 1'b1;
            pin_out   <= 1'b1;
            pin_oe_n  <= 1'b1;
            irq       <= 1'b0;
        end else begin
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            osc_out   <= next_final;
            pin_out   <= next_final;
            pin_oe_n  <= ~next_ctrl.pin_drive_enable;
            irq       <= |(next_irq_status & next_irq_enable);
        end
    end

endmodule

//--- verif/numeric_oscillator_monitor.sv
`timescale 1ns/1ps
`include "numeric_oscillator_regs.svh"

module osc_monitor #(
    parameter int ACC_WIDTH  = 20,
    parameter int STEP_WIDTH = 16
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        internal_fast_osc,
    input wire logic        logic_cell_output,
    input wire logic        external_clock_pin,
    input wire logic        osc_out,
    input wire logic        pin_out,
    input wire logic        pin_oe_n,
    input wire logic        irq
);
    logic take, wr_ctl, wr_ien, wr_clr, rd_ctl, on_seen, oe_seen, pol_seen;
    assign take = hsel && hready && htrans[1];
    // ----
    // shadow of what software last wrote, tracked from the data phase
    // ----
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {wr_ctl, wr_ien, wr_clr, rd_ctl} <= 4'h0;
            {on_seen, oe_seen, pol_seen} <= 3'h0;
        end else begin
            wr_ctl <= take && hwrite && haddr[7:0] == `OFS_OSCILLATOR_CONTROL;
            wr_ien <= take && hwrite && haddr[7:0] == `OFS_IRQ_ENABLE;
            wr_clr <= take && hwrite && haddr[7:0] == `OFS_IRQ_CLEAR;
            rd_ctl <= take && !hwrite && haddr[7:0] == `OFS_OSCILLATOR_CONTROL;
            if (wr_ctl) begin
                {on_seen, oe_seen, pol_seen} <= {hwdata[7], hwdata[6], hwdata[4]};
            end
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_pin_enable_follow: assert property (wr_ctl |-> ##2 pin_oe_n == !oe_seen)
        else $error("pin enable does not follow control write");
    chk_pin_data_same: assert property (!pin_oe_n |-> pin_out == osc_out)
        else $error("driven pin differs from output");
    chk_disabled_rests: assert property (wr_ctl && !hwdata[7] |->
        ##3 (osc_out == !pol_seen)[*4])
        else $error("disabled output not at inactive level");
    chk_level_readback: assert property (rd_ctl && $stable(osc_out) |->
        hrdata[5] == osc_out)
        else $error("output level bit differs from output");
    chk_irq_masked: assert property (wr_ien && !hwdata[0] |-> ##2 !irq)
        else $error("irq high while masked");
    chk_clear_drops_irq: assert property (wr_clr && hwdata[0] && !on_seen |-> ##2 !irq)
        else $error("irq high after clear");
    chk_upper_read_zero: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_bus_ready_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or error response");
    cov_irq_rise: cover property ($rose(irq));
    cov_pin_toggle: cover property (!pin_oe_n && $changed(osc_out));
    cov_ctl_read: cover property (rd_ctl);
endmodule

bind numeric_oscillator osc_monitor #(.ACC_WIDTH(ACC_WIDTH), .STEP_WIDTH(STEP_WIDTH)) mon (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .internal_fast_osc(internal_fast_osc), .logic_cell_output(logic_cell_output),
    .external_clock_pin(external_clock_pin), .osc_out(osc_out), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .irq(irq));

//--- verif/osc_partner.sv
`timescale 1ns/1ps

module osc_partner (
    input  wire logic [2:0] run,
    input  wire logic       pin_out,
    input  wire logic       pin_oe_n,
    output logic            fast_clk,
    output logic            cell_clk,
    output logic            ext_clk,
    output logic            pin_level
);
    // ----
    // clock sources stand at zero while stopped; unequal periods keep phases apart
    // ----
    initial begin
        fast_clk = 1'b0;
        forever #200 fast_clk = run[0] ? !fast_clk : 1'b0;
    end
    initial begin
        cell_clk = 1'b0;
        forever #250 cell_clk = run[1] ? !cell_clk : 1'b0;
    end
    initial begin
        ext_clk = 1'b0;
        forever #300 ext_clk = run[2] ? !ext_clk : 1'b0;
    end
    // a released pin is pulled up, so it never keeps the last driven level
    assign pin_level = pin_oe_n ? 1'b1 : pin_out;
endmodule

//--- verif/tb.sv
`timescale 1ns/1ps
`include "numeric_oscillator_regs.svh"

module tb;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdat;
        logic [7:0] rexp;
    } row_t;
    localparam logic [7:0] a_ctl = `OFS_OSCILLATOR_CONTROL;
    localparam logic [7:0] a_clk = `OFS_OSCILLATOR_CLOCK_CONTROL;
    localparam logic [7:0] a_alo = `OFS_ACCUMULATOR_LOW;
    localparam logic [7:0] a_ahi = `OFS_ACCUMULATOR_HIGH;
    localparam logic [7:0] a_aup = `OFS_ACCUMULATOR_UPPER;
    localparam logic [7:0] a_ilo = `OFS_INCREMENT_LOW;
    localparam logic [7:0] a_ihi = `OFS_INCREMENT_HIGH;
    localparam logic [7:0] a_sta = `OFS_IRQ_STATUS;
    localparam logic [7:0] a_clr = `OFS_IRQ_CLEAR;
    localparam logic [7:0] a_ien = `OFS_IRQ_ENABLE;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic        osc_out, pin_out, pin_oe_n, irq, pin_level, fast_clk, cell_clk, ext_clk;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize, run, sel;
    logic [7:0]  rd, save;
    int          num_errors, samples_checked, n;
    row_t        rows [12];
    assign hready = hreadyout;
    numeric_oscillator uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .internal_fast_osc(fast_clk),
        .logic_cell_output(cell_clk), .external_clock_pin(ext_clk), .osc_out(osc_out),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .irq(irq));
    osc_partner far (.run(run), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .fast_clk(fast_clk),
        .cell_clk(cell_clk), .ext_clk(ext_clk), .pin_level(pin_level));
    // ----
    // helpers
    // ----
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata[7:0];
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input string w, input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        check(w, {8'h0, e}, {8'h0, rd});
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge hclk);
    endtask
    task automatic wait_lvl(input logic v);
        n = 0;
        while (osc_out !== v && n < 2000) begin
            @(negedge hclk);
            n++;
        end
    endtask
    task automatic hold_len();
        logic v;
        v = osc_out;
        n = 0;
        while (osc_out === v && n < 2000) begin
            @(negedge hclk);
            n++;
        end
    endtask
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    initial begin
        #3000000;
        num_errors++;
        close_out();
    end
    // ----
    // main sequence
    // ----
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, run} = '0;
        hsize = 3'h2;
        num_errors = 0;
        samples_checked = 0;
        rows = '{'{a_ctl, 8'h2F, 8'h21}, '{a_ctl, 8'h5E, 8'h50}, '{a_clk, 8'hFF, 8'hE3},
                 '{a_clk, 8'h1C, 8'h00}, '{a_alo, 8'hA5, 8'hA5}, '{a_ahi, 8'h5A, 8'h5A},
                 '{a_aup, 8'hFF, 8'h0F}, '{a_ilo, 8'h34, 8'h34}, '{a_ihi, 8'h12, 8'h12},
                 '{a_ien, 8'hFF, 8'h01}, '{a_sta, 8'hFF, 8'h00}, '{8'h28, 8'hFF, 8'h00}};
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdat);
            cyc(4);
            rdchk("register readback", rows[i].addr, rows[i].rexp);
        end
        // second reset after every register except irq clear was written
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        check("oe after reset", 16'h1, pin_oe_n);
        foreach (rows[i]) begin
            rdchk("reset value", rows[i].addr, rows[i].addr == a_ilo ? 8'h01 :
                  rows[i].addr == a_ctl ? 8'h20 : 8'h00);
        end
        wr(a_ihi, 8'h10);
        wr(a_ilo, 8'h00);
        wr(a_clk, 8'hE1);
        wr(a_ctl, 8'hD0);
        hold_len();
        hold_len();
        check("toggle span", 16'h0100, n[15:0]);
        // first overflow has just raised the active-high output
        check("pin level", 16'h1, pin_level);
        wr(a_ctl, 8'hD1);
        // widths up to 128 stay below the 256-tick overflow period
        for (int k = 0; k < 8; k++) begin
            wr(a_clk, {k[2:0], 5'h01});
            wait_lvl(1'b0);
            wait_lvl(1'b1);
            hold_len();
            check("pulse width", 16'h1 << k, n[15:0]);
        end
        // a low level can only come from a driven pin, the release level is high
        check("pin low", 16'h0, pin_level);
        wr(a_ctl, 8'hC1);
        wait_lvl(1'b1);
        wait_lvl(1'b0);
        hold_len();
        check("low pulse width", 16'h0080, n[15:0]);
        wr(a_ien, 8'h00);
        wr(a_clr, 8'h01);
        cyc(300);
        check("irq masked", 16'h0, irq);
        rdchk("status set", a_sta, 8'h01);
        wr(a_ien, 8'h01);
        cyc(3);
        check("irq raised", 16'h1, irq);
        wr(a_ctl, 8'h50);
        cyc(5);
        wr(a_clr, 8'h01);
        cyc(3);
        check("irq cleared", 16'h0, irq);
        rdchk("status cleared", a_sta, 8'h00);
        bus(1'b0, a_ahi, 8'h00);
        save = rd;
        cyc(20);
        rdchk("frozen accumulator", a_ahi, save);
        // first add from FFF00 carries out of the top bit; low byte never moves
        wr(a_ihi, 8'h01);
        wr(a_ilo, 8'h00);
        wr(a_clk, 8'h01);
        for (int c = 1; c < 4; c++) begin
            sel = c == 1 ? 3'h1 : c == 2 ? 3'h2 : 3'h4;
            wr(a_aup, 8'h0F);
            wr(a_ahi, 8'hFF);
            wr(a_alo, 8'h00);
            wr(a_clk, {6'h0, c == 1 ? 2'h0 : c[1:0]});
            wr(a_ctl, 8'h80);
            run <= ~sel;
            cyc(60);
            rdchk("idle source status", a_sta, 8'h00);
            run <= sel;
            cyc(60);
            rdchk("selected source status", a_sta, 8'h01);
            run <= 3'h0;
            wr(a_ctl, 8'h00);
            rdchk("accumulator low", a_alo, 8'h00);
            wr(a_clr, 8'h01);
        end
        close_out();
    end
endmodule
